// *** cit_pkg.sv ***
// Purpose: Shared constants for the 8-bit capture/interval timer
// Assumes: 8-bit register port, one clock
// Notes:   Offsets are register indices on the plain port
package cit_pkg;

   localparam int DW = 8;
   localparam int AW = 3;

   // Register offsets
   localparam logic [AW-1:0] OFS_MODE = 3'h0;
   localparam logic [AW-1:0] OFS_CNT  = 3'h1;
   localparam logic [AW-1:0] OFS_FALL = 3'h2;
   localparam logic [AW-1:0] OFS_RISE = 3'h3;
   localparam logic [AW-1:0] OFS_PIN  = 3'h4;
   localparam logic [AW-1:0] OFS_IRQ  = 3'h5;

   // Mode register fields
   localparam int B_OVF_HI  = 7;
   localparam int B_OVF_LO  = 6;
   localparam int B_OVF_IEN = 5;
   localparam int B_IEDGE   = 4;
   localparam int B_CCLRH   = 3;
   localparam int B_CCLRL   = 2;
   localparam int B_CKSH    = 1;
   localparam int B_CKSL    = 0;

   // Pin function register fields
   localparam int B_PINSEL = 0;
   localparam int B_NFEN   = 1;

   // Interrupt register fields
   localparam int B_TIRQ  = 0;
   localparam int B_TIEN  = 1;

   localparam logic [DW-1:0] RST_VAL  = 8'h00;
   localparam logic [DW-1:0] CNT_MAX  = 8'hFF;

   // Clock select codes
   localparam logic [1:0] CKS_D64 = 2'h0;
   localparam logic [1:0] CKS_D32 = 2'h1;
   localparam logic [1:0] CKS_D2  = 2'h2;
   localparam logic [1:0] CKS_W2  = 2'h3;

   // Prescaler taps
   localparam int PS_W    = 6;
   localparam int TAP_D64 = 5;
   localparam int TAP_D32 = 4;
   localparam int TAP_D2  = 0;

   localparam int NF_LEN = 5;

   typedef enum logic [2:0] {
      PM_ACTIVE,
      PM_SLEEP,
      PM_WATCH,
      PM_SUBACT,
      PM_SUBSLP,
      PM_STANDBY
   } pwr_mode_t;

endpackage

// *** cap_timer.sv ***
// Purpose: 8-bit up-counter with input capture and interval modes
// Assumes: all inputs synchronous to mclk; watch clock sampled as a level
// Notes:   register port with read data one cycle after the read strobe
//
// How it works
// - Pin select 1 gives capture timer, 0 gives interval timer.
// - Reset clears mode register, counter and both capture registers.
// - After reset the counter steps on system clock divided by 64.
// - Two-bit clock select picks one of four internal clocks.
// - Select 00 /64, 01 /32, 10 /2, 11 watch clock /2.
// - Rising capture edge loads rise register, falling edge loads fall register.
// - Capture edge matching edge select sets timer interrupt flag.
// - Edge select 0 picks rising, 1 picks falling; reset value 0.
// - Counter clears on chosen capture edges or never.
// - Clear field 00 none, 01 falling, 10 rising, 11 both.
// - Capture mode overflow sets high or low flag by signal level.
// - Overflow with overflow enable sets the timer interrupt flag.
// - Interval mode wrap FF to 00 sets the low overflow flag.
// - Filter off: capture pulses come straight from input edges.
// - Filter on: capture pulses lag input by five sampling clocks.
// - Five-stage filter updates output only when all stages agree.
// - Watch and standby halt counter; registers retain their values.
// - Sub modes run only with watch clock /2 selected.
// - Watch clock /2 is resynchronised to the system clock.
// - Counter steps on falling edge of selected clock, switching included.
// - Toggling pin select with pin high gives a false edge.
// - Changing filter or pin select mid-filter gives false edges.
// - Unselected pin presents a low capture signal.
module cap_timer (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  srst,
   // Register port
   input  wire logic [cit_pkg::AW-1:0] addr,
   input  wire logic [cit_pkg::DW-1:0] wdata,
   input  wire logic                  wr_stb,
   input  wire logic                  rd_stb,
   output logic      [cit_pkg::DW-1:0] rdata_q,
   // Pins and system state
   input  wire logic                  capture_pin,
   input  wire logic                  watch_clk,
   input  wire cit_pkg::pwr_mode_t    pwr_mode,
   // Interrupt request
   output logic                       irq_q
);

   logic [cit_pkg::DW-1:0]   mode_q, mode_d;
   logic [cit_pkg::DW-1:0]   cnt_q, cnt_d;
   logic [cit_pkg::DW-1:0]   fall_q, fall_d;
   logic [cit_pkg::DW-1:0]   rise_q, rise_d;
   logic                     pinsel_q, pinsel_d;
   logic                     nfen_q, nfen_d;
   logic                     tirq_q, tirq_d;
   logic                     tien_q, tien_d;
   logic [1:0]               arm_q, arm_d;
   logic [cit_pkg::PS_W-1:0] ps_q, ps_d;
   logic                     wprev_q, wprev_d;
   logic                     wdiv_q, wdiv_d;
   logic                     selclk_q, selclk_d;
   logic [cit_pkg::NF_LEN-1:0] nf_q, nf_d;
   logic                     nfout_q, nfout_d;
   logic                     cap_q, cap_d;
   logic [cit_pkg::DW-1:0]   rdata_d;
   logic                     irq_d;

   logic [1:0] cks;
   logic       selclk;
   logic       run;
   logic       tick;
   logic       samp;
   logic       cap_in;
   logic       cap_rise;
   logic       cap_fall;
   logic       clr;
   logic       ovf;
   logic       set_h;
   logic       set_l;
   logic       wr_mode;

   function automatic logic reg_hit(input logic stb,
                                    input logic [cit_pkg::AW-1:0] a,
                                    input logic [cit_pkg::AW-1:0] ofs);
      reg_hit = stb && (a == ofs);
   endfunction

   assign cks = mode_q[cit_pkg::B_CKSH:cit_pkg::B_CKSL];
   assign wr_mode = reg_hit(wr_stb, addr, cit_pkg::OFS_MODE);

   // Clock selection, watch clock divider and timer gating
   always_comb begin
      ps_d    = ps_q + 1'b1;
      wprev_d = watch_clk;
      wdiv_d  = wdiv_q ^ (watch_clk & ~wprev_q);
      case (cks)
         cit_pkg::CKS_D64: selclk = ps_q[cit_pkg::TAP_D64];
         cit_pkg::CKS_D32: selclk = ps_q[cit_pkg::TAP_D32];
         cit_pkg::CKS_D2:  selclk = ps_q[cit_pkg::TAP_D2];
         cit_pkg::CKS_W2:  selclk = wdiv_q;
         default:          selclk = ps_q[cit_pkg::TAP_D64];
      endcase
      selclk_d = selclk;
      case (pwr_mode)
         cit_pkg::PM_ACTIVE,
         cit_pkg::PM_SLEEP:   run = 1'b1;
         cit_pkg::PM_SUBACT,
         cit_pkg::PM_SUBSLP:  run = (cks == cit_pkg::CKS_W2);
         default:             run = 1'b0;
      endcase
      tick = run && selclk_q && !selclk;
      samp = run && !selclk_q && selclk;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ps_q     <= '0;
         wprev_q  <= 1'b0;
         wdiv_q   <= 1'b0;
         selclk_q <= 1'b0;
      end else begin
         ps_q     <= ps_d;
         wprev_q  <= wprev_d;
         wdiv_q   <= wdiv_d;
         selclk_q <= selclk_d;
      end
   end

   // Noise filter and internal capture signal
   always_comb begin
      nf_d    = nf_q;
      nfout_d = nfout_q;
      if (samp) begin
         nf_d = {nf_q[cit_pkg::NF_LEN-2:0], capture_pin};
      end
      if (&nf_q) begin
         nfout_d = 1'b1;
      end else if (~|nf_q) begin
         nfout_d = 1'b0;
      end
      cap_in = nfen_q ? nfout_q : capture_pin;
      if (!run) begin
         cap_d = cap_q;
      end else begin
         cap_d = pinsel_q && cap_in;
      end
      cap_rise = cap_d && !cap_q;
      cap_fall = !cap_d && cap_q;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         nf_q    <= '0;
         nfout_q <= 1'b0;
         cap_q   <= 1'b0;
      end else begin
         nf_q    <= nf_d;
         nfout_q <= nfout_d;
         cap_q   <= cap_d;
      end
   end

   // Counter, captures, flags and registers
   always_comb begin
      mode_d   = mode_q;
      cnt_d    = cnt_q;
      fall_d   = fall_q;
      rise_d   = rise_q;
      pinsel_d = pinsel_q;
      nfen_d   = nfen_q;
      tirq_d   = tirq_q;
      tien_d   = tien_q;
      arm_d    = arm_q;

      clr = (cap_rise && mode_q[cit_pkg::B_CCLRH]) ||
            (cap_fall && mode_q[cit_pkg::B_CCLRL]);
      ovf = tick && !clr && (cnt_q == cit_pkg::CNT_MAX);

      if (clr) begin
         cnt_d = cit_pkg::RST_VAL;
      end else if (tick) begin
         cnt_d = cnt_q + 1'b1;
      end
      if (cap_rise) begin
         rise_d = cnt_q;
      end
      if (cap_fall) begin
         fall_d = cnt_q;
      end

      set_h = ovf && pinsel_q && cap_q;
      set_l = ovf && !(pinsel_q && cap_q);

      if (reg_hit(wr_stb, addr, cit_pkg::OFS_MODE)) begin
         mode_d[cit_pkg::B_OVF_IEN:0] = wdata[cit_pkg::B_OVF_IEN:0];
         if (!wdata[cit_pkg::B_OVF_HI] && arm_q[1]) begin
            mode_d[cit_pkg::B_OVF_HI] = 1'b0;
         end
         if (!wdata[cit_pkg::B_OVF_LO] && arm_q[0]) begin
            mode_d[cit_pkg::B_OVF_LO] = 1'b0;
         end
         arm_d = 2'h0;
      end
      if (reg_hit(rd_stb, addr, cit_pkg::OFS_MODE)) begin
         arm_d = {mode_q[cit_pkg::B_OVF_HI], mode_q[cit_pkg::B_OVF_LO]};
      end
      if (set_h) begin
         mode_d[cit_pkg::B_OVF_HI] = 1'b1;
      end
      if (set_l) begin
         mode_d[cit_pkg::B_OVF_LO] = 1'b1;
      end

      if (reg_hit(wr_stb, addr, cit_pkg::OFS_PIN)) begin
         pinsel_d = wdata[cit_pkg::B_PINSEL];
         nfen_d   = wdata[cit_pkg::B_NFEN];
      end
      if (reg_hit(wr_stb, addr, cit_pkg::OFS_IRQ)) begin
         tien_d = wdata[cit_pkg::B_TIEN];
         if (!wdata[cit_pkg::B_TIRQ]) begin
            tirq_d = 1'b0;
         end
      end
      if ((cap_rise && !mode_q[cit_pkg::B_IEDGE]) ||
          (cap_fall && mode_q[cit_pkg::B_IEDGE])) begin
         tirq_d = 1'b1;
      end
      if ((set_h || set_l) && mode_q[cit_pkg::B_OVF_IEN]) begin
         tirq_d = 1'b1;
      end

      irq_d   = tirq_q && tien_q;
      rdata_d = '0;
      if (rd_stb) begin
         case (addr)
            cit_pkg::OFS_MODE: rdata_d = mode_q;
            cit_pkg::OFS_CNT:  rdata_d = cnt_q;
            cit_pkg::OFS_FALL: rdata_d = fall_q;
            cit_pkg::OFS_RISE: rdata_d = rise_q;
            cit_pkg::OFS_PIN: begin
               rdata_d[cit_pkg::B_PINSEL] = pinsel_q;
               rdata_d[cit_pkg::B_NFEN]   = nfen_q;
            end
            cit_pkg::OFS_IRQ: begin
               rdata_d[cit_pkg::B_TIRQ] = tirq_q;
               rdata_d[cit_pkg::B_TIEN] = tien_q;
            end
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         mode_q   <= cit_pkg::RST_VAL;
         cnt_q    <= cit_pkg::RST_VAL;
         fall_q   <= cit_pkg::RST_VAL;
         rise_q   <= cit_pkg::RST_VAL;
         pinsel_q <= 1'b0;
         nfen_q   <= 1'b0;
         tirq_q   <= 1'b0;
         tien_q   <= 1'b0;
         arm_q    <= 2'h0;
         rdata_q  <= '0;
         irq_q    <= 1'b0;
      end else begin
         mode_q   <= mode_d;
         cnt_q    <= cnt_d;
         fall_q   <= fall_d;
         rise_q   <= rise_d;
         pinsel_q <= pinsel_d;
         nfen_q   <= nfen_d;
         tirq_q   <= tirq_d;
         tien_q   <= tien_d;
         arm_q    <= arm_d;
         rdata_q  <= rdata_d;
         irq_q    <= irq_d;
      end
   end

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   a_rise_capture: assert property (cap_rise |=> rise_q == $past(cnt_q))
      else $error("rise capture value wrong");

   a_fall_capture: assert property (cap_fall |=> fall_q == $past(cnt_q))
      else $error("fall capture value wrong");

   a_clear_edge: assert property (
      cap_rise && mode_q[cit_pkg::B_CCLRH] |=> cnt_q == cit_pkg::RST_VAL)
      else $error("counter not cleared on rising edge");

   a_fall_clear: assert property (
      cap_fall && mode_q[cit_pkg::B_CCLRL] |=> cnt_q == cit_pkg::RST_VAL)
      else $error("counter not cleared on falling edge");

   a_count_step: assert property (
      tick && !clr |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("counter did not step on clock fall");

   a_interval_ovf: assert property (
      !pinsel_q && tick && cnt_q == cit_pkg::CNT_MAX |=> mode_q[cit_pkg::B_OVF_LO])
      else $error("interval overflow flag not set");

   a_high_ovf: assert property (
      tick && !clr && cnt_q == cit_pkg::CNT_MAX && pinsel_q && cap_q
      |=> mode_q[cit_pkg::B_OVF_HI])
      else $error("high overflow flag not set");

   a_ovf_irq: assert property (
      tick && !clr && cnt_q == cit_pkg::CNT_MAX && mode_q[cit_pkg::B_OVF_IEN] |=> tirq_q)
      else $error("overflow did not raise the interrupt flag");

   a_edge_irq: assert property (
      cap_fall && mode_q[cit_pkg::B_IEDGE] |=> tirq_q ##1 (irq_q == $past(tien_q)))
      else $error("falling edge interrupt missing");

   a_rise_irq: assert property (
      cap_rise && !mode_q[cit_pkg::B_IEDGE] |=> tirq_q)
      else $error("rising edge interrupt missing");

   a_irq_level: assert property (
      irq_q == ($past(tirq_q) && $past(tien_q)))
      else $error("interrupt request does not follow flag and enable");

   a_pin_low: assert property (!pinsel_q && run |=> !cap_q)
      else $error("capture signal high with pin unselected");

   a_false_rise: assert property (
      run && pinsel_q && !nfen_q && capture_pin && !cap_q |-> cap_rise)
      else $error("pin edge not seen as rising capture");

   a_filter_path: assert property (
      run && nfen_q |=> cap_q == ($past(pinsel_q) && $past(nfout_q)))
      else $error("filtered capture signal wrong");

   a_standby_halt: assert property (
      pwr_mode == cit_pkg::PM_STANDBY |-> !cap_rise ##1 $stable(cnt_q))
      else $error("counter moved in standby");

   a_watch_halt: assert property (
      pwr_mode == cit_pkg::PM_WATCH |=> $stable(cnt_q))
      else $error("counter moved in watch mode");

   a_capture_hold: assert property (
      !run |=> $stable(rise_q) && $stable(fall_q))
      else $error("capture register changed while halted");

   a_filter_hold: assert property (
      nfen_q && !(&nf_q) && (|nf_q) |=> $stable(nfout_q))
      else $error("filter output changed without agreement");

   a_filter_set: assert property (
      (&nf_q) |=> nfout_q)
      else $error("filter output not set on agreement");

   a_filter_clr: assert property (
      (~|nf_q) |=> !nfout_q)
      else $error("filter output not cleared on agreement");

   a_flag_w1: assert property (
      wr_mode && wdata[cit_pkg::B_OVF_HI] && !mode_q[cit_pkg::B_OVF_HI] && !set_h
      |=> !mode_q[cit_pkg::B_OVF_HI])
      else $error("software set the high overflow flag");

   a_flag_clear: assert property (
      wr_mode && !wdata[cit_pkg::B_OVF_LO] && arm_q[0] && !set_l
      |=> !mode_q[cit_pkg::B_OVF_LO])
      else $error("armed low overflow flag not cleared");

   a_sub_gate: assert property (
      (pwr_mode == cit_pkg::PM_SUBACT || pwr_mode == cit_pkg::PM_SUBSLP)
      && cks != cit_pkg::CKS_W2 |-> !tick && !samp)
      else $error("counter ticked in sub mode without watch clock");

endmodule // cap_timer

// *** pulse_src.sv ***
// Purpose: Far-side model of the signal on the capture pin
// Assumes: bench sets the idle level and asks for pulses
// Notes:   A pulse is the inverse of the idle level for len cycles
module pulse_src (
   // Clock
   input  wire logic        mclk,
   // Bench control
   input  wire logic        base,
   input  wire logic        go,
   input  wire logic [15:0] len,
   // Capture pin
   output logic             pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_q = 16'h0000;

   always @(posedge mclk) begin
      if (go) begin
         cnt_q <= len;
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end
   assign pin = base ^ (cnt_q != 16'h0000);
endmodule // pulse_src

// *** tb_top.sv ***
// Purpose: Self-checking bench for the capture/interval timer
// Assumes: pulse_src drives the capture pin; watch clock from a divider
// Notes:   Counter figures are checked with one count of slack, halted counts exactly
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 9000;
   logic                   mclk;
   logic                   srst;
   logic [cit_pkg::AW-1:0] addr;
   logic [cit_pkg::DW-1:0] wdata;
   logic                   wr_stb;
   logic                   rd_stb;
   logic [cit_pkg::DW-1:0] rdata_q;
   logic                   capture_pin;
   logic                   watch_clk;
   cit_pkg::pwr_mode_t     pwr_mode;
   logic                   irq_q;
   logic                   base;
   logic                   go;
   logic [15:0]            len;
   logic [7:0]             v;
   logic [7:0]             w;
   logic [7:0]             rate [4];
   logic [1:0]             wdiv = 2'h0;
   int                     fails;
   int                     check_count;
   int                     cyc_cnt;

   cap_timer u_cap_timer (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .capture_pin(capture_pin),
      .watch_clk(watch_clk), .pwr_mode(pwr_mode), .irq_q(irq_q));
   pulse_src u_pulse_src (.mclk(mclk), .base(base), .go(go), .len(len), .pin(capture_pin));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) wdiv <= wdiv + 2'h1;
   assign watch_clk = wdiv[1];

   task automatic final_report;
      if (fails == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc_cnt++;
      if (cyc_cnt == LIMIT) begin
         fails++;
         final_report();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 d = rdata_q;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
      check_count++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic ex(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi);
      logic [7:0] d;
      rd(a, d);
      chk(d, lo, hi);
   endtask
   task automatic pls(input logic [15:0] n);
      @(posedge mclk);
      go  <= 1'b1;
      len <= n;
      @(posedge mclk);
      go  <= 1'b0;
   endtask
   task automatic wait_irq(input int n);
      int i;
      i = 0;
      while (irq_q !== 1'b1 && i < n) begin
         @(posedge mclk);
         i++;
      end
      chk({7'h00, irq_q}, 8'h01, 8'h01);
   endtask

   initial begin
      srst = 1'b1; addr = 3'h0; wdata = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
      pwr_mode = cit_pkg::PM_ACTIVE; base = 1'b0; go = 1'b0; len = 16'h0000;
      fails = 0; check_count = 0; cyc_cnt = 0;
      rate = '{8'h02, 8'h04, 8'h41, 8'h10};
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) ex(i[2:0], 8'h00, 8'h00);
      cyc(200);
      ex(cit_pkg::OFS_CNT, 8'h02, 8'h04);
      // Count rate of each clock select code
      for (int k = 0; k < 4; k++) begin
         wr(cit_pkg::OFS_MODE, {6'h00, k[1:0]});
         rd(cit_pkg::OFS_CNT, v);
         cyc(128);
         rd(cit_pkg::OFS_CNT, w);
         chk(w - v, rate[k] - 8'h01, rate[k] + 8'h01);
      end
      wr(cit_pkg::OFS_MODE, 8'h02);
      for (int k = 0; k < 6; k++) begin
         @(posedge mclk);
         pwr_mode <= cit_pkg::pwr_mode_t'(k[2:0]);
         rd(cit_pkg::OFS_CNT, v);
         cyc(128);
         rd(cit_pkg::OFS_CNT, w);
         chk(w - v, (k < 2) ? 8'h40 : 8'h00, (k < 2) ? 8'h42 : 8'h00);
      end
      wr(cit_pkg::OFS_MODE, 8'h03);
      @(posedge mclk);
      pwr_mode <= cit_pkg::PM_SUBACT;
      rd(cit_pkg::OFS_CNT, v);
      cyc(128);
      rd(cit_pkg::OFS_CNT, w);
      chk(w - v, 8'h0F, 8'h11);
      @(posedge mclk);
      pwr_mode <= cit_pkg::PM_ACTIVE;
      // Interval overflow, flag clearing and interrupt gating
      wr(cit_pkg::OFS_IRQ, 8'h02);
      wr(cit_pkg::OFS_MODE, 8'h22);
      wait_irq(600);
      ex(cit_pkg::OFS_MODE, 8'h62, 8'h62);
      wr(cit_pkg::OFS_MODE, 8'hE2);
      ex(cit_pkg::OFS_MODE, 8'h62, 8'h62);
      wr(cit_pkg::OFS_MODE, 8'h22);
      ex(cit_pkg::OFS_MODE, 8'h22, 8'h22);
      wr(cit_pkg::OFS_IRQ, 8'h03);
      ex(cit_pkg::OFS_IRQ, 8'h03, 8'h03);
      wr(cit_pkg::OFS_IRQ, 8'h02);
      cyc(2);
      chk({7'h00, irq_q}, 8'h00, 8'h00);
      wr(cit_pkg::OFS_MODE, 8'h02);
      cyc(600);
      chk({7'h00, irq_q}, 8'h00, 8'h00);
      ex(cit_pkg::OFS_MODE, 8'h42, 8'h42);
      // Capture with clearing on both edges
      wr(cit_pkg::OFS_MODE, 8'h0E);
      wr(cit_pkg::OFS_PIN, 8'h01);
      pls(16'h0028);
      cyc(4);
      ex(cit_pkg::OFS_IRQ, 8'h03, 8'h03);
      wr(cit_pkg::OFS_IRQ, 8'h02);
      cyc(40);
      ex(cit_pkg::OFS_FALL, 8'h13, 8'h15);
      ex(cit_pkg::OFS_IRQ, 8'h02, 8'h02);
      wr(cit_pkg::OFS_MODE, 8'h1E);
      @(posedge mclk);
      base <= 1'b1;
      cyc(8);
      wr(cit_pkg::OFS_IRQ, 8'h02);
      pls(16'h0028);
      cyc(4);
      ex(cit_pkg::OFS_IRQ, 8'h03, 8'h03);
      cyc(40);
      ex(cit_pkg::OFS_RISE, 8'h13, 8'h15);
      // High-level overflow, pin held high with clear set to rising edge only
      wr(cit_pkg::OFS_MODE, 8'h0A);
      cyc(600);
      rd(cit_pkg::OFS_MODE, v);
      chk({7'h00, v[7]}, 8'h01, 8'h01);
      // Clear on falling edge only
      wr(cit_pkg::OFS_MODE, 8'h06);
      pls(16'h0028);
      cyc(44);
      ex(cit_pkg::OFS_RISE, 8'h13, 8'h15);
      ex(cit_pkg::OFS_CNT, 8'h16, 8'h18);
      // Unselected pin and false edges
      wr(cit_pkg::OFS_MODE, 8'h02);
      wr(cit_pkg::OFS_PIN, 8'h00);
      wr(cit_pkg::OFS_IRQ, 8'h02);
      pls(16'h000A);
      cyc(14);
      ex(cit_pkg::OFS_IRQ, 8'h02, 8'h02);
      wr(cit_pkg::OFS_PIN, 8'h01);
      cyc(3);
      ex(cit_pkg::OFS_IRQ, 8'h03, 8'h03);
      // Noise filter
      wr(cit_pkg::OFS_PIN, 8'h00);
      @(posedge mclk);
      base <= 1'b0;
      cyc(4);
      wr(cit_pkg::OFS_PIN, 8'h02);
      wr(cit_pkg::OFS_PIN, 8'h03);
      cyc(20);
      wr(cit_pkg::OFS_IRQ, 8'h02);
      pls(16'h0006);
      cyc(20);
      ex(cit_pkg::OFS_IRQ, 8'h02, 8'h02);
      pls(16'h0028);
      cyc(6);
      ex(cit_pkg::OFS_IRQ, 8'h02, 8'h02);
      cyc(8);
      ex(cit_pkg::OFS_IRQ, 8'h03, 8'h03);
      final_report();
   end
endmodule // tb_top
